// [perf_event_pkg.sv]
// event codes, unit-mask fields and shared helpers for the event-select decode
// assumes occurrence inputs carry one bit per occurrence kind per core clock
package perf_event_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int code_w = 8;
    localparam int mask_w = 8;
    localparam int incr_w = 5;
    localparam int idx_w = 2;
    localparam int count_w_dflt = 48;
    localparam logic [idx_w-1:0] first_level_counters = 2'h2;

    // ------------------------------------------------------------
    // event codes
    // ------------------------------------------------------------
    localparam logic [code_w-1:0] l2_activity_event = 8'hf0;
    localparam logic [code_w-1:0] l2_ownership_request_event = 8'h27;
    localparam logic [code_w-1:0] data_xlate_load_miss_event = 8'h08;
    localparam logic [code_w-1:0] data_xlate_miss_event = 8'h49;
    localparam logic [code_w-1:0] instr_xlate_miss_event = 8'h85;
    localparam logic [code_w-1:0] first_level_writeback_event = 8'h28;
    localparam logic [code_w-1:0] first_level_read_event = 8'h40;

    // ------------------------------------------------------------
    // unit-mask field positions
    // ------------------------------------------------------------
    // l2 activity
    localparam int l2a_load = 0;
    localparam int l2a_own = 1;
    localparam int l2a_ifetch = 2;
    localparam int l2a_hw_prefetch = 3;
    localparam int l2a_l1_wb = 4;
    localparam int l2a_fill = 5;
    localparam int l2a_wb_l3 = 6;
    localparam int l2a_all = 7;
    // ownership requests: store states low nibble, locked states high nibble
    localparam logic [mask_w-1:0] own_store_field = 8'h0f;
    localparam logic [mask_w-1:0] own_lock_field = 8'hf0;
    localparam logic [mask_w-1:0] own_store_hit = 8'h0e;
    localparam logic [mask_w-1:0] own_lock_hit = 8'he0;
    // translation misses: bit 2 has no meaning
    localparam logic [mask_w-1:0] xlate_field = 8'hfb;
    localparam int xl_any = 0;
    localparam int xl_walk_done = 1;
    localparam int xl_walker_busy = 3;
    localparam int xl_second_level_hit = 4;
    localparam int xl_low_part = 5;
    localparam int xl_high_part = 6;
    localparam int xl_large_walk = 7;
    // first-level line states invalid/shared/exclusive/modified
    localparam logic [mask_w-1:0] state_field = 8'h0f;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // number of selected occurrences in one cycle
    function automatic logic [incr_w-1:0] sel_count(input logic [mask_w-1:0] occ, input logic [mask_w-1:0] sel);
        logic [incr_w-1:0] n;
        n = '0;
        for (int i = 0; i < mask_w; i++) begin
            n = n + {{(incr_w-1){1'b0}}, occ[i] & sel[i]};
        end
        return n;
    endfunction : sel_count

endpackage : perf_event_pkg

// [event_accum.sv]
// general counter accumulating the per-cycle increment of the decode
// assumes clear and increment are synchronous to sys_clk
`timescale 1ns/1ps
module event_accum #(
    parameter int count_w = perf_event_pkg::count_w_dflt
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic [perf_event_pkg::incr_w-1:0] incr,
    output logic [count_w-1:0] value
);
    import perf_event_pkg::*;

    logic [count_w-1:0] value_reg;
    logic [count_w-1:0] value_next;

    // clear wins, otherwise add the increment
    always_comb begin
        value_next = value_reg + {{(count_w-incr_w){1'b0}}, incr};
        if (clear) begin
            value_next = '0;
        end
    end

    // register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            value_reg <= '0;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule : event_accum

// [perf_event_select_decode.sv]
// event-select decode for one general performance counter
// assumes occurrence vectors are sampled every sys_clk, one bit per occurrence
// assumes counter_index gives the place of this counter among the four general counters
//
// Operation
// - code f0 counts second-level cache transactions by kind per mask bit.
// - code 27 low mask bits count store ownership requests by line state.
// - code 27 high mask bits count locked ownership requests by line state.
// - combined code 27 masks 0e, 0f, e0, f0 count unions of states.
// - code 08 counts load data translation misses with seven sub-kinds.
// - code 49 counts load and store data translation misses, same masks.
// - code 85 counts instruction translation misses with the same masks.
// - total minus load-only count equals store-caused data translation misses.
// - first-level data cache events count only on counters 0 and 1.
// - code 28 counts first-level writebacks by second-level line state.
// - code 40 masks 01, 02, 04 count invalid, shared, exclusive reads.
// - code 40 masks 08 and 0f count modified and all reads.
`timescale 1ns/1ps
module perf_event_select_decode #(
    parameter int count_w = perf_event_pkg::count_w_dflt,
    parameter logic [perf_event_pkg::idx_w-1:0] counter_index = 2'h0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic count_enable,
    input wire logic counter_clear,
    input wire logic [perf_event_pkg::code_w-1:0] event_code,
    input wire logic [perf_event_pkg::mask_w-1:0] unit_mask,
    input wire logic [perf_event_pkg::mask_w-1:0] l2_activity_occ,
    input wire logic [perf_event_pkg::mask_w-1:0] l2_ownership_occ,
    input wire logic [perf_event_pkg::mask_w-1:0] data_xlate_load_occ,
    input wire logic [perf_event_pkg::mask_w-1:0] data_xlate_store_occ,
    input wire logic [perf_event_pkg::mask_w-1:0] instr_xlate_occ,
    input wire logic [3:0] first_level_writeback_occ,
    input wire logic [3:0] first_level_read_occ,
    output logic [perf_event_pkg::incr_w-1:0] count_incr,
    output logic [count_w-1:0] count_value,
    output logic select_valid,
    output logic select_unsupported
);
    import perf_event_pkg::*;

    // ------------------------------------------------------------
    // decode state
    // ------------------------------------------------------------
    // registered increment and selection status
    logic [incr_w-1:0] incr_reg;
    logic [incr_w-1:0] incr_next;
    logic valid_reg;
    logic valid_next;
    logic unsup_reg;
    logic unsup_next;

    // ------------------------------------------------------------
    // code classification
    // ------------------------------------------------------------
    logic code_known;
    logic first_level_sel;
    logic first_level_ok;

    // first-level cache events are legal only on the low counters
    assign first_level_sel = (event_code == first_level_writeback_event) ||
                             (event_code == first_level_read_event);
    assign first_level_ok = counter_index < first_level_counters;

    // codes this decode serves; anything else counts nothing
    assign code_known = (event_code == l2_activity_event) ||
                        (event_code == l2_ownership_request_event) ||
                        (event_code == data_xlate_load_miss_event) ||
                        (event_code == data_xlate_miss_event) ||
                        (event_code == instr_xlate_miss_event) ||
                        first_level_sel;

    // ------------------------------------------------------------
    // unit-mask qualification
    // ------------------------------------------------------------
    logic [mask_w-1:0] l2a_sel;
    logic [mask_w-1:0] own_sel;
    logic [mask_w-1:0] xlate_sel;
    logic [mask_w-1:0] state_sel;

    // the all bit takes every transaction kind once, never twice
    always_comb begin
        l2a_sel = unit_mask;
        if (unit_mask[l2a_all]) begin
            l2a_sel = 8'h7f;
        end
        l2a_sel[l2a_all] = 1'b0;
    end

    // store states low nibble, locked states high nibble; unions add up
    assign own_sel = unit_mask & (own_store_field | own_lock_field);
    // bit 2 has no meaning on translation events and is dropped
    assign xlate_sel = unit_mask & xlate_field;
    // first-level events know only four line states
    assign state_sel = unit_mask & state_field;

    // ------------------------------------------------------------
    // per-source occurrence counts
    // ------------------------------------------------------------
    // one count per occurrence source
    logic [incr_w-1:0] l2a_count;
    logic [incr_w-1:0] own_count;
    logic [incr_w-1:0] xlate_load_count;
    logic [incr_w-1:0] xlate_store_count;
    logic [incr_w-1:0] xlate_total_count;
    logic [incr_w-1:0] instr_count;
    logic [incr_w-1:0] wb_count;
    logic [incr_w-1:0] read_count;

    // occurrences of this cycle that match a selected bit
    assign l2a_count = sel_count(l2_activity_occ, l2a_sel);
    assign own_count = sel_count(l2_ownership_occ, own_sel);
    assign xlate_load_count = sel_count(data_xlate_load_occ, xlate_sel);
    assign xlate_store_count = sel_count(data_xlate_store_occ, xlate_sel);
    assign instr_count = sel_count(instr_xlate_occ, xlate_sel);
    assign wb_count = sel_count({4'h0, first_level_writeback_occ}, state_sel);
    assign read_count = sel_count({4'h0, first_level_read_occ}, state_sel);

    // load part reused as is, so total minus load-only is the store part
    assign xlate_total_count = xlate_load_count + xlate_store_count;

    // ------------------------------------------------------------
    // increment selection
    // ------------------------------------------------------------
    // per-cycle increment of the selected event
    always_comb begin
        incr_next = '0;
        unique case (event_code)
            // second-level cache events
            l2_activity_event: begin
                incr_next = l2a_count;
            end
            l2_ownership_request_event: begin
                incr_next = own_count;
            end
            // translation misses share one mask layout
            data_xlate_load_miss_event: begin
                incr_next = xlate_load_count;
            end
            data_xlate_miss_event: begin
                incr_next = xlate_total_count;
            end
            instr_xlate_miss_event: begin
                incr_next = instr_count;
            end
            // first-level events, legality handled below
            first_level_writeback_event: begin
                incr_next = wb_count;
            end
            first_level_read_event: begin
                incr_next = read_count;
            end
            default: begin
                incr_next = '0;
            end
        endcase
        // high counters never count first-level events
        if (first_level_sel && !first_level_ok) begin
            incr_next = '0;
        end
        // a disabled counter sees nothing this cycle
        if (!count_enable) begin
            incr_next = '0;
        end
    end

    // register the increment
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            incr_reg <= '0;
        end else begin
            incr_reg <= incr_next;
        end
    end

    // ------------------------------------------------------------
    // selection status
    // ------------------------------------------------------------
    // legal selection, or first-level event on a high counter
    always_comb begin
        valid_next = code_known;
        unsup_next = 1'b0;
        if (first_level_sel && !first_level_ok) begin
            valid_next = 1'b0;
            unsup_next = 1'b1;
        end
    end

    // register the status flags
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_reg <= 1'b0;
            unsup_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            unsup_reg <= unsup_next;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    event_accum #(
        .count_w(count_w)
    ) u_accum (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(counter_clear),
        .incr(incr_reg),
        .value(count_value)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all outputs straight from flip-flops
    assign count_incr = incr_reg;
    assign select_valid = valid_reg;
    assign select_unsupported = unsup_reg;

endmodule : perf_event_select_decode

// [perf_event_checker.sv]
// checker for the event-select decode
// assumes it is bound onto perf_event_select_decode
`timescale 1ns/1ps
module perf_event_checker #(
    parameter int count_w = 48,
    parameter logic [1:0] counter_index = 2'h0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic count_enable,
    input wire logic counter_clear,
    input wire logic [7:0] event_code,
    input wire logic [7:0] unit_mask,
    input wire logic [7:0] l2_activity_occ,
    input wire logic [7:0] l2_ownership_occ,
    input wire logic [7:0] data_xlate_load_occ,
    input wire logic [7:0] data_xlate_store_occ,
    input wire logic [3:0] first_level_read_occ,
    input wire logic [4:0] count_incr,
    input wire logic [count_w-1:0] count_value,
    input wire logic select_unsupported
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    int e_l2a, e_own, e_ld, e_tot, e_rd;
    // expected increments of the current cycle
    assign e_l2a = unit_mask[7] ? $countones(l2_activity_occ & 8'h7f) : $countones(l2_activity_occ & unit_mask);
    assign e_own = $countones(l2_ownership_occ & unit_mask);
    assign e_ld = $countones(data_xlate_load_occ & unit_mask & 8'hfb);
    assign e_tot = e_ld + $countones(data_xlate_store_occ & unit_mask & 8'hfb);
    assign e_rd = $countones(first_level_read_occ & unit_mask[3:0]);
    sequence s_on(c);
        count_enable && event_code == c;
    endsequence
    chk_l2a_count: assert property (s_on(8'hf0) |=> count_incr == $past(e_l2a))
        else $error("l2 activity increment off");
    chk_own_count: assert property (s_on(8'h27) |=> count_incr == $past(e_own))
        else $error("ownership increment off");
    chk_load_xlate: assert property (s_on(8'h08) |=> count_incr == $past(e_ld))
        else $error("load translation increment off");
    chk_total_xlate: assert property (s_on(8'h49) |=> count_incr == $past(e_tot))
        else $error("total translation increment off");
    chk_read_count: assert property (count_enable && event_code == 8'h40 && counter_index < 2 |=> count_incr == $past(e_rd))
        else $error("first level read increment off");
    chk_l1_blocked: assert property (count_enable && event_code inside {8'h28, 8'h40} && counter_index >= 2 |=> count_incr == 0)
        else $error("first level event counted on a high counter");
    chk_l1_counter: assert property (event_code inside {8'h28, 8'h40} |=> select_unsupported == (counter_index >= 2))
        else $error("first level support flag off");
    chk_clear_wins: assert property (counter_clear |=> count_value == 0)
        else $error("counter not cleared");
    chk_count_sum: assert property (!counter_clear |=> count_value == $past(count_value) + $past(count_incr))
        else $error("counter did not add increment");
endmodule : perf_event_checker

// [tb_top.sv]
// self-checking bench for the event-select decode
// assumes the checker is compiled before this file
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic count_enable = 1'b0;
    logic counter_clear = 1'b0;
    logic [7:0] event_code = 8'h00;
    logic [7:0] unit_mask = 8'h00;
    logic [7:0] l2a = 8'h35, own = 8'hb6, ld = 8'h9b, st = 8'h6f, ins = 8'hd3;
    logic [3:0] wb = 4'ha, rd = 4'h7;
    logic [4:0] count_incr;
    logic [47:0] count_value;
    logic select_valid, select_unsupported;
    logic [4:0] count_incr_hi;
    logic [47:0] count_value_hi;
    logic select_valid_hi, select_unsupported_hi;
    logic l1_code;
    int n_fail = 0, num_checks = 0, acc = 0;
    logic [7:0] codes [8] = '{8'hf0, 8'h27, 8'h08, 8'h49, 8'h85, 8'h28, 8'h40, 8'h41};
    logic [7:0] masks [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h0e, 8'h0f, 8'he0, 8'hf0};
    always #12.5 sys_clk = ~sys_clk;
    perf_event_select_decode u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .count_enable(count_enable),
        .counter_clear(counter_clear), .event_code(event_code), .unit_mask(unit_mask), .l2_activity_occ(l2a),
        .l2_ownership_occ(own), .data_xlate_load_occ(ld), .data_xlate_store_occ(st), .instr_xlate_occ(ins),
        .first_level_writeback_occ(wb), .first_level_read_occ(rd), .count_incr(count_incr),
        .count_value(count_value), .select_valid(select_valid), .select_unsupported(select_unsupported));
    // third counter: first-level events are refused there
    perf_event_select_decode #(.counter_index(2'h2)) u_dut_hi (.sys_clk(sys_clk), .rst_b(rst_b),
        .count_enable(count_enable), .counter_clear(counter_clear), .event_code(event_code), .unit_mask(unit_mask),
        .l2_activity_occ(l2a), .l2_ownership_occ(own), .data_xlate_load_occ(ld), .data_xlate_store_occ(st),
        .instr_xlate_occ(ins), .first_level_writeback_occ(wb), .first_level_read_occ(rd),
        .count_incr(count_incr_hi), .count_value(count_value_hi), .select_valid(select_valid_hi),
        .select_unsupported(select_unsupported_hi));
    // ----
    // helpers
    // ----
    function automatic int exp_incr(input logic [7:0] c, input logic [7:0] m);
        case (c)
            8'hf0: return m[7] ? $countones(l2a & 8'h7f) : $countones(l2a & m);
            8'h27: return $countones(own & m);
            8'h08: return $countones(ld & m & 8'hfb);
            8'h49: return $countones(ld & m & 8'hfb) + $countones(st & m & 8'hfb);
            8'h85: return $countones(ins & m & 8'hfb);
            8'h28: return $countones(wb & m[3:0]);
            8'h40: return $countones(rd & m[3:0]);
            default: return 0;
        endcase
    endfunction : exp_incr
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // drive one cycle at the falling edge, occurrences rotate every cycle
    task automatic step(input logic [7:0] c, input logic [7:0] m, input logic clr, input logic en);
        @(negedge sys_clk);
        event_code = c;
        unit_mask = m;
        counter_clear = clr;
        count_enable = en;
        {l2a, own, ld, st, ins} = {own, ld, st, ins, l2a};
        {wb, rd} = {rd, wb};
        @(posedge sys_clk);
        #1;
    endtask : step
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // ----
    // tests
    // ----
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        // each listed code against each of the twelve listed masks, back to back
        foreach (codes[i]) begin
            foreach (masks[j]) begin
                step(codes[i], masks[j], 1'b0, 1'b1);
                check("count_incr", count_incr, exp_incr(codes[i], masks[j]));
                check("select_valid", select_valid, codes[i] != 8'h41);
                check("select_unsupported", select_unsupported, 1'b0);
                l1_code = codes[i] inside {8'h28, 8'h40};
                check("count_incr_hi", count_incr_hi, l1_code ? 0 : exp_incr(codes[i], masks[j]));
                check("select_valid_hi", select_valid_hi, codes[i] != 8'h41 && !l1_code);
                check("select_unsupported_hi", select_unsupported_hi, l1_code);
            end
        end
        // clear, then three counted cycles and idle ones
        step(8'h00, 8'h00, 1'b1, 1'b0);
        check("count_value", count_value, 48'h0);
        repeat (3) begin
            step(8'h27, 8'hff, 1'b0, 1'b1);
            acc += exp_incr(8'h27, 8'hff);
        end
        step(8'h27, 8'hff, 1'b0, 1'b0);
        step(8'h27, 8'hff, 1'b0, 1'b0);
        check("count_value", count_value, acc);
        check("count_value_hi", count_value_hi, acc);
        // reset in mid-run empties counter and increment at once
        @(negedge sys_clk);
        rst_b = 1'b0;
        #1;
        check("count_value", count_value, 48'h0);
        check("count_incr", count_incr, 5'h00);
        check("count_value_hi", count_value_hi, 48'h0);
        @(negedge sys_clk);
        rst_b = 1'b1;
        // counting resumes after the release
        step(8'hf0, 8'h80, 1'b0, 1'b1);
        acc = exp_incr(8'hf0, 8'h80);
        check("count_incr", count_incr, acc);
        step(8'h00, 8'h00, 1'b0, 1'b0);
        check("count_value", count_value, acc);
        final_report();
    end
    initial begin
        #100us;
        n_fail++;
        final_report();
    end
endmodule : tb_top
bind perf_event_select_decode perf_event_checker #(.count_w(count_w), .counter_index(counter_index)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .count_enable(count_enable), .counter_clear(counter_clear),
    .event_code(event_code), .unit_mask(unit_mask), .l2_activity_occ(l2_activity_occ),
    .l2_ownership_occ(l2_ownership_occ), .data_xlate_load_occ(data_xlate_load_occ),
    .data_xlate_store_occ(data_xlate_store_occ), .first_level_read_occ(first_level_read_occ),
    .count_incr(count_incr), .count_value(count_value), .select_unsupported(select_unsupported));
